//--- core/asl_alert_summary.sv
// alert summary register bank with self-test flags, behind a wishbone slave
//
// Behaviour
// - full-scale self-test failure sets bit 2 when zero/full-scale test enabled
// - the three self-test flags clear only by writing 0; 1 keeps them
// - comparator high accuracy failure sets bit 1 if scan 001/010 and enabled
// - comparator low accuracy failure sets bit 0 under the same arming
// - summary bit 15 is OR of fourteen cell ADC high alerts
// - summary bit 14 is OR of fourteen cell comparator high alerts
// - summary bit 13 is OR of fourteen cell ADC low alerts
// - summary bit 12 is OR of fourteen cell comparator low alerts
// - summary bit 11 is OR of six aux ADC cold alerts
// - summary bit 10 is OR of six aux comparator cold alerts
// - summary bit 9 is OR of six aux ADC hot alerts
// - summary bit 8 is OR of six aux comparator hot alerts
// - summary alert bits are read only and clear once sources resolve
// - bit 4 flags bad ADC offset calibration; good result clears it
// - bit 3 flags bad ramp offset calibration; good result clears it
// - bit 2 flags bad ratiometric offset calibration; good result clears it
// - bit 1 flags bad pyramid gain calibration; good result clears it
// - bit 0 flags bad ramp gain calibration; good result clears it
// - summary register at index 0x7 is read only, resets 0, bits 7..5 unused
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
module asl_alert_summary #(
  parameter int               CAL_W  = asl_pkg::CAL_W,
  parameter logic [CAL_W-1:0] CAL_LO = CAL_W'(asl_pkg::CAL_LO_DEF),
  parameter logic [CAL_W-1:0] CAL_HI = CAL_W'(asl_pkg::CAL_HI_DEF)
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone classic slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // acquisition side
  input  wire logic                     acq_done_i,
  input  wire asl_pkg::asl_tests_t      test_fail_i,
  input  wire asl_pkg::asl_alerts_t     alerts_i,
  input  wire logic [asl_pkg::NUM_CAL-1:0] cal_done_i,
  input  wire logic [asl_pkg::NUM_CAL-1:0][CAL_W-1:0] cal_result_i,
  // configuration towards the scan engine
  output logic      [2:0]               scan_configuration_o,
  output logic                          comparator_accuracy_enable_o,
  output logic                          zero_full_selftest_enable_o,
  output logic      [asl_pkg::NUM_CAL-1:0][CAL_W-1:0] cal_value_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // comparator accuracy tests only run for the two listed scan modes
  function automatic logic acc_armed(input logic [2:0] cfg,
                                     input logic       en);
    return en && (cfg == asl_pkg::SCAN_CFG_A || cfg == asl_pkg::SCAN_CFG_B);
  endfunction

  // byte-lane merge so partial writes keep untouched bytes
  function automatic logic [CAL_W-1:0] merge_bytes(
    input logic [CAL_W-1:0] old_v,
    input logic [31:0]      new_v,
    input logic [3:0]       sel
  );
    logic [CAL_W-1:0] m;
    m = old_v;
    for (int i = 0; i < CAL_W; i++) begin
      m[i] = sel[i / 8] ? new_v[i] : old_v[i];
    end
    return m;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                        req;
  logic                        wr_fire;
  logic [5:0]                  idx;
  logic [5:0]                  cal_off;
  logic                        cal_in;
  logic                        ack_reg;
  logic [31:0]                 dat_reg;
  logic [31:0]                 rd_data;
  logic [4:0]                  cfg_reg;
  logic [2:0]                  tests_reg;
  logic [2:0]                  tests_next;
  logic [15:0]                 sum_reg;
  logic [15:0]                 sum_next;
  logic                        armed;
  logic                        fs_event;
  logic                        hi_event;
  logic                        lo_event;
  logic [asl_pkg::NUM_CAL-1:0] cal_fault;

  // ****************************************************************
  // wishbone slave
  // ****************************************************************

  // word index from the byte address; the low two bits are ignored
  assign idx     = wb_adr_i[7:2];
  assign cal_off = idx - asl_pkg::IDX_CAL_BASE;
  assign cal_in  = (cal_off < 6'(asl_pkg::NUM_CAL));
  assign req     = wb_cyc_i & wb_stb_i;

  // writes land on the edge where the master samples ack high
  assign wr_fire = req & wb_we_i & ack_reg;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // read data captured with the ack; unmapped words answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      dat_reg <= wb_we_i ? 32'h0000_0000 : rd_data;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // read mux; bits above each register's width read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (idx)
      asl_pkg::IDX_SELFTEST: begin
        rd_data[2:0] = tests_reg;
      end
      asl_pkg::IDX_SUMMARY: begin
        rd_data[15:0] = sum_reg;
      end
      asl_pkg::IDX_CONFIG: begin
        rd_data[4:0] = cfg_reg;
      end
      default: begin
        if (cal_in) begin
          rd_data[CAL_W-1:0] = cal_value_o[cal_off[2:0]];
        end
      end
    endcase
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************

  // scan mode and test enables, written through byte lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= asl_pkg::CONFIG_RST;
    end else if (wr_fire && idx == asl_pkg::IDX_CONFIG && wb_sel_i[0]) begin
      cfg_reg <= wb_dat_i[4:0];
    end
  end

  assign scan_configuration_o         = cfg_reg[2:0];
  assign comparator_accuracy_enable_o = cfg_reg[asl_pkg::CFG_ACC_EN];
  assign zero_full_selftest_enable_o  = cfg_reg[asl_pkg::CFG_ZFS_EN];

  // ****************************************************************
  // self-test result flags
  // ****************************************************************

  // results are only looked at on the acquisition-done pulse
  assign armed    = acc_armed(cfg_reg[2:0], cfg_reg[asl_pkg::CFG_ACC_EN]);
  assign fs_event = acq_done_i & cfg_reg[asl_pkg::CFG_ZFS_EN] &
                    test_fail_i.fullscale_selftest_fail;
  assign hi_event = acq_done_i & armed &
                    test_fail_i.comparator_accuracy_high_fail;
  assign lo_event = acq_done_i & armed &
                    test_fail_i.comparator_accuracy_low_fail;

  // clear by writing 0 first, then a failure sets, so set beats clear
  always_comb begin
    tests_next = tests_reg;
    if (wr_fire && idx == asl_pkg::IDX_SELFTEST && wb_sel_i[0]) begin
      tests_next = tests_reg & wb_dat_i[2:0];
    end
    if (fs_event) begin
      tests_next[asl_pkg::ST_FULLSCALE] = 1'b1;
    end
    if (hi_event) begin
      tests_next[asl_pkg::ST_ACC_HIGH] = 1'b1;
    end
    if (lo_event) begin
      tests_next[asl_pkg::ST_ACC_LOW] = 1'b1;
    end
  end

  // a passing run leaves a stored failure alone until software clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tests_reg <= asl_pkg::SELFTEST_RST;
    end else begin
      tests_reg <= tests_next;
    end
  end

  // ****************************************************************
  // summary register
  // ****************************************************************

  // the per-input alert registers upstream refresh on each acquisition,
  // so following their OR makes the summary clear with them
  always_comb begin
    sum_next = asl_pkg::SUMMARY_RST;
    sum_next[asl_pkg::SUM_CELL_ADC_HIGH] =
      |alerts_i.cell_adc_high_alerts;
    sum_next[asl_pkg::SUM_CELL_CMP_HIGH] =
      |alerts_i.cell_comparator_high_alerts;
    sum_next[asl_pkg::SUM_CELL_ADC_LOW] =
      |alerts_i.cell_adc_low_alerts;
    sum_next[asl_pkg::SUM_CELL_CMP_LOW] =
      |alerts_i.cell_comparator_low_alerts;
    sum_next[asl_pkg::SUM_AUX_ADC_COLD] =
      |alerts_i.aux_adc_cold_alerts;
    sum_next[asl_pkg::SUM_AUX_CMP_COLD] =
      |alerts_i.aux_comparator_cold_alerts;
    sum_next[asl_pkg::SUM_AUX_ADC_HOT] =
      |alerts_i.aux_adc_hot_alerts;
    sum_next[asl_pkg::SUM_AUX_CMP_HOT] =
      |alerts_i.aux_comparator_hot_alerts;
    sum_next[asl_pkg::NUM_CAL-1:0] = cal_fault;
  end

  // no write path: bus writes to this word are simply dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_reg <= asl_pkg::SUMMARY_RST;
    end else begin
      sum_reg <= sum_next;
    end
  end

  // ****************************************************************
  // calibration channels (index 0 ramp gain .. 4 adc offset)
  // ****************************************************************
  for (genvar k = 0; k < asl_pkg::NUM_CAL; k++) begin : g_cal
    logic             hit;
    logic [CAL_W-1:0] wr_value;

    assign hit      = wr_fire && cal_in && (cal_off == 6'(k));
    assign wr_value = merge_bytes(cal_value_o[k], wb_dat_i, wb_sel_i);

    asl_cal_check #(
      .W  (CAL_W),
      .LO (CAL_LO),
      .HI (CAL_HI)
    ) u_chk (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .cal_valid_i (cal_done_i[k]),
      .cal_value_i (cal_result_i[k]),
      .wr_i        (hit),
      .wr_value_i  (wr_value),
      .value_o     (cal_value_o[k]),
      .fault_o     (cal_fault[k])
    );
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  fs_fail_set_a: assert property (
    fs_event |=> tests_reg[asl_pkg::ST_FULLSCALE])
    else $error("full-scale failure not recorded");

  fs_gate_off_a: assert property (
    (!zero_full_selftest_enable_o && !tests_reg[asl_pkg::ST_FULLSCALE])
    |=> !tests_reg[asl_pkg::ST_FULLSCALE])
    else $error("full-scale flag set while test disabled");

  write_one_keep_a: assert property (
    (wr_fire && idx == asl_pkg::IDX_SELFTEST && wb_sel_i[0] &&
     wb_dat_i[asl_pkg::ST_ACC_LOW] && tests_reg[asl_pkg::ST_ACC_LOW])
    |=> tests_reg[asl_pkg::ST_ACC_LOW])
    else $error("writing one disturbed a self-test flag");

  write_zero_clr_a: assert property (
    (wr_fire && idx == asl_pkg::IDX_SELFTEST && wb_sel_i[0] &&
     wb_dat_i[2:0] == 3'h0 && !acq_done_i) |=> tests_reg == 3'h0)
    else $error("writing zero did not clear self-test flags");

  acc_high_set_a: assert property (
    (acq_done_i && test_fail_i.comparator_accuracy_high_fail &&
     comparator_accuracy_enable_o && scan_configuration_o == 3'h2)
    |=> tests_reg[asl_pkg::ST_ACC_HIGH])
    else $error("comparator high failure not recorded");

  acc_low_gate_a: assert property (
    (!armed && !tests_reg[asl_pkg::ST_ACC_LOW])
    |=> !tests_reg[asl_pkg::ST_ACC_LOW])
    else $error("comparator low flag set while disarmed");

  cell_summary_a: assert property (
    ##1 sum_reg[15:12] == {|$past(alerts_i.cell_adc_high_alerts),
                           |$past(alerts_i.cell_comparator_high_alerts),
                           |$past(alerts_i.cell_adc_low_alerts),
                           |$past(alerts_i.cell_comparator_low_alerts)})
    else $error("cell summary bits disagree with alerts");

  aux_summary_a: assert property (
    ##1 sum_reg[11:8] == {|$past(alerts_i.aux_adc_cold_alerts),
                          |$past(alerts_i.aux_comparator_cold_alerts),
                          |$past(alerts_i.aux_adc_hot_alerts),
                          |$past(alerts_i.aux_comparator_hot_alerts)})
    else $error("aux summary bits disagree with alerts");

  summary_clear_a: assert property (
    (alerts_i == '0) [*2] |-> sum_reg[15:8] == 8'h00)
    else $error("summary stayed set after alerts resolved");

  summary_ro_a: assert property (
    (wr_fire && idx == asl_pkg::IDX_SUMMARY && cal_done_i == '0)
    |=> $stable(cal_fault))
    else $error("write to summary changed a calibration flag");

  unused_zero_a: assert property (
    (req && !ack_reg && !wb_we_i && idx == asl_pkg::IDX_SUMMARY)
    |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000 && wb_dat_o[7:5] == 3'h0)
    else $error("unused summary bits read nonzero");

  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // reset itself is what is checked here, so the default gating is off
  reset_clear_a: assert property (
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> sum_reg == asl_pkg::SUMMARY_RST && tests_reg == 3'h0)
    else $error("summary or self-test flags not cleared by reset");

endmodule

//--- core/asl_pkg.sv
// package: offsets, field positions, resets and carriers of the alert block
package asl_pkg;

  // ****************************************************************
  // bus geometry and register indices (byte address = 4 * index)
  // ****************************************************************
  localparam int         WB_AW        = 8;
  localparam int         WB_DW        = 32;
  localparam logic [5:0] IDX_SELFTEST = 6'h06;
  localparam logic [5:0] IDX_SUMMARY  = 6'h07;
  localparam logic [5:0] IDX_CONFIG   = 6'h10;
  localparam logic [5:0] IDX_CAL_BASE = 6'h20;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_CELL = 14;
  localparam int NUM_AUX  = 6;
  localparam int NUM_CAL  = 5;
  localparam int CAL_W    = 16;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SUM_CELL_ADC_HIGH = 15;
  localparam int SUM_CELL_CMP_HIGH = 14;
  localparam int SUM_CELL_ADC_LOW  = 13;
  localparam int SUM_CELL_CMP_LOW  = 12;
  localparam int SUM_AUX_ADC_COLD  = 11;
  localparam int SUM_AUX_CMP_COLD  = 10;
  localparam int SUM_AUX_ADC_HOT   = 9;
  localparam int SUM_AUX_CMP_HOT   = 8;
  localparam int ST_FULLSCALE      = 2;
  localparam int ST_ACC_HIGH       = 1;
  localparam int ST_ACC_LOW        = 0;
  localparam int CFG_ACC_EN        = 3;
  localparam int CFG_ZFS_EN        = 4;

  // ****************************************************************
  // encodings, reset values and calibration bounds
  // ****************************************************************
  localparam logic [2:0]  SCAN_CFG_A    = 3'h1;
  localparam logic [2:0]  SCAN_CFG_B    = 3'h2;
  localparam logic [2:0]  SELFTEST_RST  = 3'h0;
  localparam logic [15:0] SUMMARY_RST   = 16'h0000;
  localparam logic [4:0]  CONFIG_RST    = 5'h00;
  localparam logic [15:0] CAL_VALUE_RST = 16'h0000;
  localparam logic [15:0] CAL_LO_DEF    = 16'h0040;
  localparam logic [15:0] CAL_HI_DEF    = 16'h0fc0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [NUM_CELL-1:0] cell_adc_high_alerts;
    logic [NUM_CELL-1:0] cell_comparator_high_alerts;
    logic [NUM_CELL-1:0] cell_adc_low_alerts;
    logic [NUM_CELL-1:0] cell_comparator_low_alerts;
    logic [NUM_AUX-1:0]  aux_adc_cold_alerts;
    logic [NUM_AUX-1:0]  aux_comparator_cold_alerts;
    logic [NUM_AUX-1:0]  aux_adc_hot_alerts;
    logic [NUM_AUX-1:0]  aux_comparator_hot_alerts;
  } asl_alerts_t;

  typedef struct packed {
    logic fullscale_selftest_fail;
    logic comparator_accuracy_high_fail;
    logic comparator_accuracy_low_fail;
  } asl_tests_t;

endpackage

//--- core/asl_cal_check.sv
// one calibration channel: stored value and its out-of-bounds fault flag
`timescale 1ns/100ps
module asl_cal_check #(
  parameter int           W  = 16,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         cal_valid_i,
  input  wire logic [W-1:0] cal_value_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wr_value_i,
  output logic      [W-1:0] value_o,
  output logic              fault_o
);

  // ****************************************************************
  // bound check
  // ****************************************************************
  function automatic logic out_of_bounds(input logic [W-1:0] v);
    return (v < LO) || (v > HI);
  endfunction

  logic         upd;
  logic [W-1:0] new_value;

  // a calibration result wins over a write landing in the same cycle
  assign upd       = cal_valid_i | wr_i;
  assign new_value = cal_valid_i ? cal_value_i : wr_value_i;

  // value and fault follow the last calibration or write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= W'(asl_pkg::CAL_VALUE_RST);
      fault_o <= 1'b0;
    end else if (upd) begin
      value_o <= new_value;
      fault_o <= out_of_bounds(new_value);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  cal_fault_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (upd && out_of_bounds(new_value)) |=> fault_o)
    else $error("calibration fault not raised on bad result");

  cal_fault_clr_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (upd && !out_of_bounds(new_value)) |=> !fault_o && value_o == $past(new_value))
    else $error("calibration fault not cleared on good result");

endmodule

//--- sim/asl_alert_summary_test.sv
// self-checking bench for the alert summary register bank
`timescale 1ns/100ps
module asl_alert_summary_test;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                   clk_i;
  logic                   rst_i;
  logic                   wb_cyc_i;
  logic                   wb_stb_i;
  logic                   wb_we_i;
  logic [7:0]             wb_adr_i;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic                   acq_done_i;
  asl_pkg::asl_tests_t    test_fail_i;
  asl_pkg::asl_alerts_t   alerts_i;
  logic [4:0]             cal_done_i;
  logic [4:0][15:0]       cal_result_i;
  logic [2:0]             scan_configuration_o;
  logic                   comparator_accuracy_enable_o;
  logic                   zero_full_selftest_enable_o;
  logic [4:0][15:0]       cal_value_o;
  int                     error_cnt;
  int                     cmp_count;
  int                     cyc_cnt;
  logic [31:0]            rd;
  int                     lo[8] = '{66, 52, 38, 24, 18, 12, 6, 0};
  int                     wd[8] = '{14, 14, 14, 14, 6, 6, 6, 6};
  logic [7:0]             cfg[6] = '{8'h19, 8'h1a, 8'h1b, 8'h11, 8'h0a, 8'h18};
  logic [31:0]            stx[6] = '{32'h7, 32'h7, 32'h4, 32'h4, 32'h3, 32'h4};

  asl_alert_summary DUT (
    .clk_i                        (clk_i),
    .rst_i                        (rst_i),
    .wb_cyc_i                     (wb_cyc_i),
    .wb_stb_i                     (wb_stb_i),
    .wb_we_i                      (wb_we_i),
    .wb_adr_i                     (wb_adr_i),
    .wb_sel_i                     (wb_sel_i),
    .wb_dat_i                     (wb_dat_i),
    .wb_dat_o                     (wb_dat_o),
    .wb_ack_o                     (wb_ack_o),
    .acq_done_i                   (acq_done_i),
    .test_fail_i                  (test_fail_i),
    .alerts_i                     (alerts_i),
    .cal_done_i                   (cal_done_i),
    .cal_result_i                 (cal_result_i),
    .scan_configuration_o         (scan_configuration_o),
    .comparator_accuracy_enable_o (comparator_accuracy_enable_o),
    .zero_full_selftest_enable_o  (zero_full_selftest_enable_o),
    .cal_value_o                  (cal_value_o)
  );

  // ****************************************************************
  // clock, timeout and helpers
  // ****************************************************************
  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // the whole run needs well under two thousand cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got,
                       input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic cycle; the request is held until ack is sampled high
  task automatic wb_xfer(input logic [7:0] a, input logic we,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge clk_i);
    // no own limit: a missing ack is caught by the cycle ceiling
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(a, 1'b0, 32'h0, q);
    check(name, q, exp);
  endtask

  // one-cycle acquisition end with the given test failures
  task automatic acq(input logic [2:0] f);
    @(posedge clk_i);
    acq_done_i  <= 1'b1;
    test_fail_i <= f;
    @(posedge clk_i);
    acq_done_i  <= 1'b0;
    test_fail_i <= 3'h0;
  endtask

  // one-cycle calibration result on channel k
  task automatic cal(input int k, input logic [15:0] v);
    @(posedge clk_i);
    cal_done_i      <= 5'h01 << k;
    cal_result_i[k] <= v;
    @(posedge clk_i);
    cal_done_i      <= 5'h00;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk_i = 1'b0; rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
    wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    acq_done_i = 1'b0; test_fail_i = 3'h0; alerts_i = '0;
    cal_done_i = 5'h00; cal_result_i = '0;
    error_cnt = 0; cmp_count = 0; cyc_cnt = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values
    rd_chk("summary reset", 8'h1c, 32'h0);
    rd_chk("selftest reset", 8'h18, 32'h0);
    rd_chk("unmapped read", 8'hfc, 32'h0);
    // each summary bit follows its own group, lowest and highest member
    for (int g = 0; g < 8; g++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge clk_i);
        alerts_i <= 80'h1 << (lo[g] + (j == 1 ? wd[g] - 1 : 0));
        rd_chk("summary or", 8'h1c, 32'h1 << (15 - g));
        @(posedge clk_i);
        alerts_i <= '0;
        rd_chk("summary clear", 8'h1c, 32'h0);
      end
    end
    // writes to the summary register are dropped, unused bits stay 0
    @(posedge clk_i);
    alerts_i <= '1;
    wr(8'h1c, 32'h0);
    rd_chk("summary ro", 8'h1c, 32'hff00);
    @(posedge clk_i);
    alerts_i <= '0;
    wr(8'h1c, 32'hffff);
    rd_chk("summary wr", 8'h1c, 32'h0);
    wr(8'hfc, 32'hffff);
    // self-test flags under six arming settings; both tests disabled together is not driven
    for (int i = 0; i < 6; i++) begin
      wr(8'h40, {24'h0, cfg[i]});
      // the write lands on the ack edge; look once the register settled
      @(posedge clk_i);
      check("config out", {27'h0, zero_full_selftest_enable_o,
            comparator_accuracy_enable_o, scan_configuration_o},
            {24'h0, cfg[i]} & 32'h1f);
      acq(3'h7);
      rd_chk("selftest set", 8'h18, stx[i]);
      wr(8'h18, 32'h7);
      rd_chk("selftest w1", 8'h18, stx[i]);
      wr(8'h18, 32'h0);
      rd_chk("selftest w0", 8'h18, 32'h0);
    end
    // calibration faults: bounds are inclusive, write or later cal clears
    for (int k = 0; k < 5; k++) begin
      cal(k, 16'h0010);
      rd_chk("cal low", 8'h1c, 32'h1 << k);
      wr(8'h80 + 8'(4 * k), 32'h0100);
      rd_chk("cal wr ok", 8'h1c, 32'h0);
      check("cal value", {16'h0, cal_value_o[k]}, 32'h0100);
      cal(k, 16'h0fc1);
      rd_chk("cal high", 8'h1c, 32'h1 << k);
      cal(k, 16'h0fc0);
      rd_chk("cal edge ok", 8'h1c, 32'h0);
      cal(k, 16'h003f);
      wr(8'h80 + 8'(4 * k), 32'h0040);
      rd_chk("cal lo edge", 8'h1c, 32'h0);
      rd_chk("cal readback", 8'h80 + 8'(4 * k), 32'h0040);
    end
    print_verdict();
  end
endmodule
